// ===== pkg/ioagu_cfg.svh
// register offsets, field positions, reset values for the indirect address generator
// assumes a 12-bit apb byte address; every register is one aligned 32-bit word
`ifndef IOAGU_CFG_SVH
`define IOAGU_CFG_SVH

`define IOAGU_OFF_MODE 12'h000
`define IOAGU_OFF_SA01 12'h004
`define IOAGU_OFF_SA23 12'h008
`define IOAGU_OFF_SA45 12'h00C
`define IOAGU_OFF_SA67 12'h010
`define IOAGU_OFF_SAC 12'h014
`define IOAGU_OFF_SZLO 12'h018
`define IOAGU_OFF_SZHI 12'h01C
`define IOAGU_OFF_SZC 12'h020
`define IOAGU_OFF_IDX0 12'h024
`define IOAGU_OFF_IDX1 12'h028
`define IOAGU_OFF_CTRL 12'h02C
`define IOAGU_OFF_CPAGE 12'h030
`define IOAGU_OFF_XCOEF 12'h034
`define IOAGU_OFF_ERRCNT 12'h038
`define IOAGU_OFF_XAR_BASE 12'h040
`define IOAGU_XAR_MASK 12'hFE0

`define IOAGU_COEF_IDX 4'd8
`define IOAGU_MODE_MASK 16'h01FF
`define IOAGU_CTRL_LEGACY_BIT 0

`define IOAGU_RST_16 16'h0000
`define IOAGU_RST_PAGE 7'h00
`define IOAGU_RST_32 32'h0000_0000
`define IOAGU_STEP_ONE 17'h0_0001

`endif

// ===== pkg/ioagu_pkg.sv
// types shared by the indirect address generator and its bench
// no constants live here; numbers sit in ioagu_cfg.svh
package ioagu_pkg;

  typedef enum logic [4:0] {
    IOAGU_M_PLAIN,
    IOAGU_M_POST_INC,
    IOAGU_M_POST_DEC,
    IOAGU_M_PRE_INC,
    IOAGU_M_PRE_DEC,
    IOAGU_M_ADD_IDX0,
    IOAGU_M_SUB_IDX0,
    IOAGU_M_BASE_IDX0,
    IOAGU_M_BREV_ADD,
    IOAGU_M_BREV_SUB,
    IOAGU_M_ADD_IDX1,
    IOAGU_M_SUB_IDX1,
    IOAGU_M_BASE_IDX1,
    IOAGU_M_SHORT_OFS,
    IOAGU_M_BASE_LONG,
    IOAGU_M_PRE_LONG
  } ioagu_mode_e;

  typedef struct packed {
    logic io_space;
    logic bit_buffer;
    logic circ_qual;
    logic delay_instr;
    ioagu_mode_e mode;
    logic [3:0] ptr_sel;
    logic [2:0] short_k;
    logic [15:0] long_k;
  } ioagu_op_s;

  typedef struct packed {
    logic io_space;
    logic bit_buffer;
    logic [22:0] addr;
  } ioagu_result_s;

endpackage

// ===== rtl/ioagu_core.sv
// indirect operand address generator with linear/circular pointer update and apb registers
// assumes an apb3 master on ref_clk_i and an operand source on the same clock
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "ioagu_cfg.svh"

module ioagu_core
  import ioagu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic op_valid_i,
  input wire ioagu_op_s op_i,
  output logic res_valid_o,
  output ioagu_result_s res_o,
  output logic bus_error_o
);

  function automatic logic [15:0] brev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int b = 0; b < 16; b++)
    begin
      r[b] = v[15 - b];
    end
    return r;
  endfunction

  // t is wide enough that a negative sum shows in bit 17 before the wrap
  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic [16:0] d,
                                           input logic c, input logic [15:0] sz);
    logic [17:0] t;
    t = {2'b00, p} + {d[16], d};
    if (c && t[17])
    begin
      t = t + {2'b00, sz};
    end
    else if (c && (t >= {2'b00, sz}))
    begin
      t = t - {2'b00, sz};
    end
    return t[15:0];
  endfunction

  function automatic logic [16:0] neg17(input logic [15:0] v);
    return 17'(~{1'b0, v} + `IOAGU_STEP_ONE);
  endfunction

  logic [15:0] mode_reg;
  logic [15:0] sa01_reg;
  logic [15:0] sa23_reg;
  logic [15:0] sa45_reg;
  logic [15:0] sa67_reg;
  logic [15:0] sac_reg;
  logic [15:0] szlo_reg;
  logic [15:0] szhi_reg;
  logic [15:0] szc_reg;
  logic [15:0] idx0_reg;
  logic [15:0] idx1_reg;
  logic legacy_reg;
  logic [15:0] errcnt_reg;
  logic [15:0] ptr_reg [0:8];
  logic [6:0] page_reg [0:8];
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic res_valid_reg;
  ioagu_result_s res_reg;
  logic berr_reg;
  wire setup = psel_i && !penable_i;
  wire wr_en = psel_i && penable_i && pwrite_i;
  wire aligned = (paddr_i[1:0] == 2'b00);
  wire xar_hit = aligned && ((paddr_i & `IOAGU_XAR_MASK) == `IOAGU_OFF_XAR_BASE);
  wire [2:0] xar_idx = paddr_i[4:2];
  wire [8:0] ext_wr;
  wire [8:0] page_wr;
  // operand side
  wire [3:0] sel = op_i.ptr_sel;
  wire sel_ok = (sel <= `IOAGU_COEF_IDX);
  wire is_coef = (sel == `IOAGU_COEF_IDX);
  wire [15:0] cur_ptr = sel_ok ? ptr_reg[sel] : `IOAGU_RST_16;
  wire [6:0] cur_page = sel_ok ? page_reg[sel] : `IOAGU_RST_PAGE;
  wire circ = op_i.circ_qual || (sel_ok && mode_reg[sel]);
  wire [15:0] start_sel = is_coef ? sac_reg :
                          (sel[2:1] == 2'd0) ? sa01_reg :
                          (sel[2:1] == 2'd1) ? sa23_reg :
                          (sel[2:1] == 2'd2) ? sa45_reg : sa67_reg;
  wire [15:0] size_sel = is_coef ? szc_reg :
                         (legacy_reg || !sel[2]) ? szlo_reg : szhi_reg;
  wire [15:0] prim_step = legacy_reg ? ptr_reg[0] : idx0_reg;
  wire long_mode = (op_i.mode == IOAGU_M_BASE_LONG) || (op_i.mode == IOAGU_M_PRE_LONG);
  wire io_illegal = op_i.io_space && (long_mode || op_i.delay_instr);
  wire illegal = !sel_ok || io_illegal;
  wire [15:0] brev_add = brev16(brev16(cur_ptr) + brev16(prim_step));
  wire [15:0] brev_sub = brev16(brev16(cur_ptr) - brev16(prim_step));
  wire [16:0] long_step = {op_i.long_k[15], op_i.long_k};
  wire [16:0] short_step = {14'h0000, op_i.short_k};
  logic [15:0] eff_ptr;
  logic [15:0] new_ptr;
  logic upd;
  always_comb
  begin
    eff_ptr = cur_ptr;
    new_ptr = cur_ptr;
    upd = 1'b0;
    case (op_i.mode)
      IOAGU_M_PLAIN:
        upd = 1'b0;
      IOAGU_M_POST_INC:
      begin
        new_ptr = step_ptr(cur_ptr, `IOAGU_STEP_ONE, circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_POST_DEC:
      begin
        new_ptr = step_ptr(cur_ptr, neg17(16'h0001), circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_PRE_INC:
      begin
        new_ptr = step_ptr(cur_ptr, `IOAGU_STEP_ONE, circ, size_sel);
        eff_ptr = new_ptr;
        upd = 1'b1;
      end
      IOAGU_M_PRE_DEC:
      begin
        new_ptr = step_ptr(cur_ptr, neg17(16'h0001), circ, size_sel);
        eff_ptr = new_ptr;
        upd = 1'b1;
      end
      IOAGU_M_ADD_IDX0:
      begin
        new_ptr = step_ptr(cur_ptr, {1'b0, prim_step}, circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_SUB_IDX0:
      begin
        new_ptr = step_ptr(cur_ptr, neg17(prim_step), circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_BASE_IDX0:
        eff_ptr = step_ptr(cur_ptr, {1'b0, prim_step}, circ, size_sel);
      IOAGU_M_BREV_ADD:
      begin
        new_ptr = brev_add;
        upd = !circ;
      end
      IOAGU_M_BREV_SUB:
      begin
        new_ptr = brev_sub;
        upd = !circ;
      end
      IOAGU_M_ADD_IDX1:
      begin
        new_ptr = step_ptr(cur_ptr, {1'b0, idx1_reg}, circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_SUB_IDX1:
      begin
        new_ptr = step_ptr(cur_ptr, neg17(idx1_reg), circ, size_sel);
        upd = 1'b1;
      end
      IOAGU_M_BASE_IDX1:
        eff_ptr = step_ptr(cur_ptr, {1'b0, idx1_reg}, circ, size_sel);
      IOAGU_M_SHORT_OFS:
        eff_ptr = step_ptr(cur_ptr, short_step, circ, size_sel);
      IOAGU_M_BASE_LONG:
        eff_ptr = step_ptr(cur_ptr, long_step, circ, size_sel);
      IOAGU_M_PRE_LONG:
      begin
        new_ptr = step_ptr(cur_ptr, long_step, circ, size_sel);
        eff_ptr = new_ptr;
        upd = 1'b1;
      end
      default:
        upd = 1'b0;
    endcase
  end

  // start is the origin only in circular mode; bit buffers and i/o carry no page
  wire [15:0] addr_low = circ ? 16'(start_sel + eff_ptr) : eff_ptr;
  wire [6:0] addr_page = (op_i.io_space || op_i.bit_buffer) ? `IOAGU_RST_PAGE : cur_page;
  wire accept = op_valid_i && !illegal;
  wire ptr_upd = accept && upd;
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_ptr
      if (gi < 8)
      begin : g_aux
        assign ext_wr[gi] = wr_en && xar_hit && (xar_idx == 3'(gi));
        assign page_wr[gi] = 1'b0;
      end
      else
      begin : g_coef
        assign ext_wr[gi] = wr_en && (paddr_i == `IOAGU_OFF_XCOEF);
        assign page_wr[gi] = wr_en && (paddr_i == `IOAGU_OFF_CPAGE);
      end
      // a software write to the same pointer in the same cycle overrides the update
      always_ff @(posedge ref_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          ptr_reg[gi] <= `IOAGU_RST_16;
          page_reg[gi] <= `IOAGU_RST_PAGE;
        end
        else if (ext_wr[gi])
        begin
          ptr_reg[gi] <= pwdata_i[15:0];
          page_reg[gi] <= pwdata_i[22:16];
        end
        else
        begin
          if (page_wr[gi])
          begin
            page_reg[gi] <= pwdata_i[6:0];
          end
          if (ptr_upd && (sel == 4'(gi)))
          begin
            ptr_reg[gi] <= new_ptr;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_reg <= `IOAGU_RST_16;
      sa01_reg <= `IOAGU_RST_16;
      sa23_reg <= `IOAGU_RST_16;
      sa45_reg <= `IOAGU_RST_16;
      sa67_reg <= `IOAGU_RST_16;
      sac_reg <= `IOAGU_RST_16;
      szlo_reg <= `IOAGU_RST_16;
      szhi_reg <= `IOAGU_RST_16;
      szc_reg <= `IOAGU_RST_16;
      idx0_reg <= `IOAGU_RST_16;
      idx1_reg <= `IOAGU_RST_16;
      legacy_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (paddr_i == `IOAGU_OFF_MODE)
        mode_reg <= pwdata_i[15:0] & `IOAGU_MODE_MASK;
      else if (paddr_i == `IOAGU_OFF_SA01)
        sa01_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SA23)
        sa23_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SA45)
        sa45_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SA67)
        sa67_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SAC)
        sac_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SZLO)
        szlo_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SZHI)
        szhi_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_SZC)
        szc_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_IDX0)
        idx0_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_IDX1)
        idx1_reg <= pwdata_i[15:0];
      else if (paddr_i == `IOAGU_OFF_CTRL)
        legacy_reg <= pwdata_i[`IOAGU_CTRL_LEGACY_BIT];
    end
  end

  // read data is captured in the setup phase so prdata comes from a flop with no wait state
  logic [31:0] prdata_next;
  logic pslverr_next;
  always_comb
  begin
    prdata_next = `IOAGU_RST_32;
    pslverr_next = 1'b0;
    if (paddr_i == `IOAGU_OFF_MODE)
      prdata_next = {16'h0000, mode_reg};
    else if (paddr_i == `IOAGU_OFF_SA01)
      prdata_next = {16'h0000, sa01_reg};
    else if (paddr_i == `IOAGU_OFF_SA23)
      prdata_next = {16'h0000, sa23_reg};
    else if (paddr_i == `IOAGU_OFF_SA45)
      prdata_next = {16'h0000, sa45_reg};
    else if (paddr_i == `IOAGU_OFF_SA67)
      prdata_next = {16'h0000, sa67_reg};
    else if (paddr_i == `IOAGU_OFF_SAC)
      prdata_next = {16'h0000, sac_reg};
    else if (paddr_i == `IOAGU_OFF_SZLO)
      prdata_next = {16'h0000, szlo_reg};
    else if (paddr_i == `IOAGU_OFF_SZHI)
      prdata_next = {16'h0000, szhi_reg};
    else if (paddr_i == `IOAGU_OFF_SZC)
      prdata_next = {16'h0000, szc_reg};
    else if (paddr_i == `IOAGU_OFF_IDX0)
      prdata_next = {16'h0000, idx0_reg};
    else if (paddr_i == `IOAGU_OFF_IDX1)
      prdata_next = {16'h0000, idx1_reg};
    else if (paddr_i == `IOAGU_OFF_CTRL)
      prdata_next = {31'h0000_0000, legacy_reg};
    else if (paddr_i == `IOAGU_OFF_CPAGE)
      prdata_next = {25'h000_0000, page_reg[8]};
    else if (paddr_i == `IOAGU_OFF_XCOEF)
      prdata_next = {9'h000, page_reg[8], ptr_reg[8]};
    else if (paddr_i == `IOAGU_OFF_ERRCNT)
      prdata_next = {16'h0000, errcnt_reg};
    else if (xar_hit)
      prdata_next = {9'h000, page_reg[xar_idx], ptr_reg[xar_idx]};
    else
      pslverr_next = 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prdata_reg <= `IOAGU_RST_32;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg <= pwrite_i ? `IOAGU_RST_32 : prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      res_valid_reg <= 1'b0;
      res_reg <= '0;
      berr_reg <= 1'b0;
      errcnt_reg <= `IOAGU_RST_16;
    end
    else
    begin
      res_valid_reg <= accept;
      berr_reg <= op_valid_i && illegal;
      if (accept)
      begin
        res_reg <= '{io_space: op_i.io_space, bit_buffer: op_i.bit_buffer,
                     addr: {addr_page, addr_low}};
      end
      if (op_valid_i && illegal)
      begin
        errcnt_reg <= errcnt_reg + 16'h0001;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pslverr_o = pslverr_reg;
  assign pready_o = 1'b1;
  assign res_valid_o = res_valid_reg;
  assign res_o = res_reg;
  assign bus_error_o = berr_reg;

endmodule

// ===== tb/ioagu_bus_sink.sv
// stand-in for the i/o and data-memory buses that take each generated address
// logs every answer in order; the bench drains the log
`timescale 1ns/100ps
module ioagu_bus_sink
  import ioagu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic res_valid_i,
  input wire ioagu_result_s res_i,
  input wire logic bus_error_i
);
  logic [25:0] got_q[$];
  // a refused access carries no address, so only the flag is kept
  always @(posedge ref_clk_i)
  begin
    if (resetn_i && bus_error_i)
      got_q.push_back(26'h200_0000);
    else if (resetn_i && res_valid_i)
      got_q.push_back({1'b0, res_i});
  end
endmodule

// ===== tb/ioagu_monitor.sv
// port-level checks for the indirect address generator
// bound to ioagu_core from the bench top; sees the core's ports only
`timescale 1ns/100ps
`include "ioagu_cfg.svh"
module ioagu_monitor
  import ioagu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic op_valid_i,
  input wire ioagu_op_s op_i,
  input wire logic res_valid_o,
  input wire ioagu_result_s res_o,
  input wire logic bus_error_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire long_w = op_i.mode inside {IOAGU_M_BASE_LONG, IOAGU_M_PRE_LONG};
  wire bad_w = op_i.ptr_sel > `IOAGU_COEF_IDX || op_i.io_space && (long_w || op_i.delay_instr);
  // 03C is the one gap inside the map
  wire hole_w = paddr_i[1:0] != 2'h0 || paddr_i == 12'h03C || paddr_i > 12'h05C;
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_bad_op;
    op_valid_i && bad_w;
  endsequence
  sequence s_good_op;
    op_valid_i && !bad_w;
  endsequence
  AST_LONG_IO: assert property (op_valid_i && op_i.io_space && long_w |=> bus_error_o)
    else $error("long constant i/o operand not refused");
  AST_DELAY_IO: assert property (op_valid_i && op_i.io_space && op_i.delay_instr
    |=> bus_error_o && !res_valid_o) else $error("delay i/o operand not refused");
  AST_BAD_OP: assert property (s_bad_op |=> bus_error_o && !res_valid_o)
    else $error("illegal operand without bus error");
  AST_GOOD_OP: assert property (s_good_op |=> res_valid_o && !bus_error_o)
    else $error("legal operand without result");
  AST_QUIET: assert property (!op_valid_i |=> !res_valid_o && !bus_error_o)
    else $error("output pulse without operand");
  AST_RES_HOLD: assert property (!res_valid_o |-> $stable(res_o))
    else $error("result changed without valid");
  AST_IO_PAGE: assert property (res_valid_o && (res_o.io_space || res_o.bit_buffer)
    |-> res_o.addr[22:16] == 7'h00) else $error("page applied to i/o or bit address");
  AST_UNMAPPED: assert property (s_setup ##0 hole_w |=> pslverr_o)
    else $error("unmapped access not flagged");
  AST_MAPPED: assert property (s_setup ##0 !hole_w |=> !pslverr_o)
    else $error("mapped access flagged");
  AST_MODE_BITS: assert property (s_setup ##0 (!pwrite_i && paddr_i == `IOAGU_OFF_MODE)
    |=> prdata_o[31:9] == 23'h00_0000) else $error("mode register upper bits set");
endmodule

// ===== tb/tb.sv
// self-checking bench: apb register traffic, operand stream, integer reference model
// assumes ioagu_monitor and ioagu_bus_sink are compiled before this file
`timescale 1ns/100ps
`include "ioagu_cfg.svh"
module tb
  import ioagu_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, op_valid_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  ioagu_op_s op_i = '0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, res_valid_o, bus_error_o, er;
  ioagu_result_s res_o;
  int bad_count = 0, n_tests = 0, seed = 5;
  int ptr[9], pg[9], st[5], sz[3], ix0, ix1, leg, mreg, errs;
  logic [25:0] exp_q[$];
  ioagu_core ioagu_core_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .op_valid_i(op_valid_i),
    .op_i(op_i), .res_valid_o(res_valid_o), .res_o(res_o), .bus_error_o(bus_error_o));
  ioagu_bus_sink ioagu_bus_sink_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .res_valid_i(res_valid_o), .res_i(res_o), .bus_error_i(bus_error_o));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    if (n == 20) chk("pready", 0, 1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wreg(input int a, input int d);
    int i;
    apb(1'b1, 12'(a), d);
    if (a == 0) mreg = d & 32'h0000_01FF;
    else if (a >= 4 && a <= 20) st[a / 4 - 1] = d & 32'h0000_FFFF;
    else if (a >= 24 && a <= 32) sz[a / 4 - 6] = d & 32'h0000_FFFF;
    else if (a == 36) ix0 = d & 32'h0000_FFFF;
    else if (a == 40) ix1 = d & 32'h0000_FFFF;
    else if (a == 44) leg = d & 1;
    else if (a == 48) pg[8] = d & 32'h0000_007F;
    if (a == 52 || a >= 64 && a <= 92)
    begin
      i = a == 52 ? 8 : a / 4 - 16;
      ptr[i] = d & 32'h0000_FFFF;
      pg[i] = (d >> 16) & 32'h0000_007F;
    end
  endtask
  task rreg(input int a, input logic [31:0] e, input logic ee);
    apb(1'b0, 12'(a), 32'h0000_0000);
    chk("rdata", rd, e);
    chk("slverr", er, ee);
  endtask
  function automatic int wrap(int t, int c, int s);
    if (c && s != 0 && t < 0) t += s;
    else if (c && s != 0 && t >= s) t -= s;
    return t & 32'h0000_FFFF;
  endfunction
  function automatic int brev(int v);
    int r = 0;
    for (int b = 0; b < 16; b++) r[15 - b] = v[b];
    return r;
  endfunction
  task op(input ioagu_op_s o);
    int p, c, s, b, e, np, k, s0;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    p = o.ptr_sel;
    if (p > 8 || o.io_space && (o.mode inside {IOAGU_M_BASE_LONG, IOAGU_M_PRE_LONG}
        || o.delay_instr))
    begin
      exp_q.push_back(26'h200_0000);
      errs++;
      return;
    end
    c = o.circ_qual | mreg[p];
    s = p == 8 ? sz[2] : (p < 4 || leg) ? sz[0] : sz[1];
    b = p == 8 ? st[4] : st[p / 2];
    s0 = leg ? ptr[0] : ix0;
    k = $signed(o.long_k);
    np = ptr[p];
    e = np;
    case (o.mode)
      IOAGU_M_POST_INC, IOAGU_M_PRE_INC: np = wrap(np + 1, c, s);
      IOAGU_M_POST_DEC, IOAGU_M_PRE_DEC: np = wrap(np - 1, c, s);
      IOAGU_M_ADD_IDX0: np = wrap(np + s0, c, s);
      IOAGU_M_SUB_IDX0: np = wrap(np - s0, c, s);
      IOAGU_M_BASE_IDX0: e = wrap(e + s0, c, s);
      IOAGU_M_BREV_ADD: np = c ? np : brev(brev(np) + brev(s0));
      IOAGU_M_BREV_SUB: np = c ? np : brev(brev(np) - brev(s0));
      IOAGU_M_ADD_IDX1: np = wrap(np + ix1, c, s);
      IOAGU_M_SUB_IDX1: np = wrap(np - ix1, c, s);
      IOAGU_M_BASE_IDX1: e = wrap(e + ix1, c, s);
      IOAGU_M_SHORT_OFS: e = wrap(e + o.short_k, c, s);
      IOAGU_M_BASE_LONG: e = wrap(e + k, c, s);
      IOAGU_M_PRE_LONG: np = wrap(np + k, c, s);
      default: ;
    endcase
    if (o.mode inside {IOAGU_M_PRE_INC, IOAGU_M_PRE_DEC, IOAGU_M_PRE_LONG}) e = np;
    ptr[p] = np;
    if (c) e = (e + b) & 32'h0000_FFFF;
    exp_q.push_back({1'b0, o.io_space, o.bit_buffer,
      (o.io_space | o.bit_buffer) ? 7'h00 : 7'(pg[p]), 16'(e)});
  endtask
  task flush;
    logic [25:0] g;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    while (exp_q.size() > 0)
    begin
      g = ioagu_bus_sink_i.got_q.size() > 0 ? ioagu_bus_sink_i.got_q.pop_front() : '1;
      chk("result", g, exp_q.pop_front());
    end
    chk("extra", ioagu_bus_sink_i.got_q.size(), 0);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    test_done;
  end
  initial
  begin
    ioagu_op_s o;
    int p;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a <= 32; a += 4)
    begin
      rreg(a, 32'h0000_0000, 1'b0);
      wreg(a, -1);
      rreg(a, a == 0 ? 32'h0000_01FF : 32'h0000_FFFF, 1'b0);
      wreg(a, 0);
    end
    rreg(60, 32'h0000_0000, 1'b1);
    rreg(2, 32'h0000_0000, 1'b1);
    $display("test registers done");
    // three-word circular buffer in page 1, pointer 1 stepping past its end
    wreg(24, 3);
    wreg(0, 32'h0000_0012);
    wreg(68, 32'h0001_0000);
    wreg(4, 32'h0000_0A02);
    o = '0;
    o.mode = IOAGU_M_POST_INC;
    o.ptr_sel = 4'd1;
    repeat (4) op(o);
    flush;
    rreg(68, pg[1] << 16 | ptr[1], 1'b0);
    // legacy: pointer zero is the step and the low size serves pointer 4
    wreg(44, 1);
    wreg(28, 100);
    wreg(64, 2);
    wreg(80, 2);
    o.ptr_sel = 4'd4;
    o.mode = IOAGU_M_ADD_IDX0;
    op(o);
    o.mode = IOAGU_M_BREV_ADD;
    op(o);
    o.mode = IOAGU_M_PLAIN;
    op(o);
    flush;
    wreg(44, 0);
    $display("test circular done");
    o.io_space = 1'b1;
    o.mode = IOAGU_M_BASE_LONG;
    op(o);
    o.mode = IOAGU_M_PRE_LONG;
    op(o);
    o.mode = IOAGU_M_PLAIN;
    o.delay_instr = 1'b1;
    op(o);
    o = '0;
    o.ptr_sel = 4'd9;
    op(o);
    flush;
    wreg(56, 7);
    rreg(56, errs, 1'b0);
    $display("test illegal done");
    for (int a = 24; a <= 32; a += 4) wreg(a, 16);
    for (int i = 0; i < 96; i++)
    begin
      // pointers and steps stay below the size of 16
      o = $random(seed);
      o.mode = ioagu_mode_e'(i % 16);
      o.ptr_sel = 4'({$random(seed)} % 10);
      o.long_k = 16'({$random(seed)} % 31 - 15);
      p = o.ptr_sel;
      wreg(0, $random(seed));
      wreg(44, $random(seed));
      wreg(36, {$random(seed)} % 16);
      wreg(40, {$random(seed)} % 16);
      wreg(4 + 4 * ({$random(seed)} % 5), $random(seed));
      wreg(64, {$random(seed)} % 16);
      if (p < 9) wreg(p == 8 ? 52 : 64 + 4 * p, {$random(seed)} % 128 << 16 | {$random(seed)} % 16);
      if (p == 8) wreg(48, $random(seed));
      op(o);
      flush;
      if (p < 9) rreg(p == 8 ? 52 : 64 + 4 * p, pg[p] << 16 | ptr[p], 1'b0);
    end
    $display("test random done");
    test_done;
  end
endmodule
bind ioagu_core ioagu_monitor ioagu_monitor_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .op_valid_i(op_valid_i), .op_i(op_i), .res_valid_o(res_valid_o), .res_o(res_o),
  .bus_error_o(bus_error_o));
